// file: dv/jtg_tap_checker.sv
// Concurrent checks on the pins of the test access port.
`include "jtg_map.vh"
module jtg_tap_checker (
    input logic clk_sys_i, // System clock.
    input logic resetn_i, // Reset, active low.
    input logic tck_i, // Test clock pin.
    input logic tms_i, // Mode select pin.
    input logic tdi_i, // Serial in pin.
    input logic trstn_i, // Test reset pin, active low.
    input logic tdo_o, // Serial out pin.
    input logic tdo_oe_o, // Serial out enable.
    input logic [`JTG_PIN_W-1:0] pin_in_i, // Functional input pins.
    input logic [`JTG_PIN_W-1:0] core_in_o, // Values seen by the core.
    input logic [`JTG_PIN_W-1:0] core_out_i, // Core outputs.
    input logic [`JTG_PIN_W-1:0] pin_out_o, // Output pins.
    input logic tlr_o // Reset state flag.
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========
    // Pin relations, all in the system clock domain.
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);
    AST_TRST_FORCE: assert property ($fell(trstn_i) |-> ##[1:5] (tlr_o && !tdo_oe_o))
        else $error("test reset did not force the reset state");
    AST_TRST_HOLD: assert property ((!trstn_i)[*5] |-> tlr_o)
        else $error("reset state left while test reset low");
    AST_TDO_FALL: assert property ($changed(tdo_o) && trstn_i |-> !tck_i)
        else $error("serial out changed while test clock high");
    AST_TLR_LEAVE: assert property (tlr_o && trstn_i && !tms_i && $rose(tck_i)
        |-> ##[1:6] !tlr_o)
        else $error("reset state kept with mode select low");
    AST_OE_IDLE: assert property (tlr_o |-> !tdo_oe_o)
        else $error("serial out driven in reset state");
    AST_OE_RISE: assert property ($rose(tdo_oe_o) |-> !tck_i && !tlr_o)
        else $error("serial out enabled while test clock high");
    AST_PIN_FUNC: assert property (($stable(core_out_i) && tlr_o)[*4]
        |-> pin_out_o == core_out_i)
        else $error("output pins not functional in reset state");
    AST_CORE_FUNC: assert property (($stable(pin_in_i) && tlr_o)[*6]
        |-> core_in_o == pin_in_i)
        else $error("core inputs not functional in reset state");
endmodule // jtg_tap_checker

bind jtg_tap jtg_tap_checker u_chk (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .tck_i(tck_i), .tms_i(tms_i), .tdi_i(tdi_i), .trstn_i(trstn_i), .tdo_o(tdo_o),
    .tdo_oe_o(tdo_oe_o), .pin_in_i(pin_in_i), .core_in_o(core_in_o),
    .core_out_i(core_out_i), .pin_out_o(pin_out_o), .tlr_o(tlr_o));

// file: dv/jtg_tester_model.sv
// Behavioural board tester that drives the test pins.
module jtg_tester_model (
    input logic clk_sys_i, // Bench clock, used for timing only.
    input logic tdo_i, // Serial out from the device.
    input logic tdo_oe_i, // High while the device drives serial out.
    output logic tck_o = 1'b0, // Test clock, still between frames.
    output logic tms_o = 1'b1, // Mode select, high keeps the reset state.
    output logic tdi_o = 1'b0, // Serial in.
    output logic trstn_o = 1'b1 // Test reset, active low.
);
    timeunit 1ns;
    timeprecision 1ps;

    // One 160 ns test clock period; inputs move only while the clock is low.
    task automatic cyc(input logic m, input logic d, output logic q);
        tms_o = m;
        tdi_o = d;
        repeat (8) @(negedge clk_sys_i);
        q = tdo_oe_i ? tdo_i : ~tdo_i; // A released line reads as garbage.
        tck_o = 1'b1;
        repeat (8) @(negedge clk_sys_i);
        tck_o = 1'b0;
    endtask

    // Full scan of the instruction or data path from idle, ending in idle.
    task automatic scan(input logic ir, input logic [31:0] din, input int n,
                        output logic [31:0] dout);
        logic q;
        dout = 32'h0;
        cyc(1'b0, 1'b0, q);
        cyc(1'b1, 1'b0, q);
        if (ir) cyc(1'b1, 1'b0, q);
        cyc(1'b0, 1'b0, q);
        cyc(1'b0, 1'b0, q);
        for (int i = 0; i < n; i++) begin
            cyc(i == n - 1, din[i], q);
            dout[i] = q;
        end
        cyc(1'b1, 1'b0, q);
        cyc(1'b0, 1'b0, q);
    endtask

    // Five clocks with mode select high return to the reset state.
    task automatic to_reset;
        logic q;
        repeat (5) cyc(1'b1, 1'b0, q);
    endtask

    // Hold test reset low for a number of system clocks.
    task automatic test_reset(input int n);
        trstn_o = 1'b0;
        repeat (n) @(negedge clk_sys_i);
        trstn_o = 1'b1;
    endtask
endmodule // jtg_tester_model

// file: dv/tb_jtg_tap.sv
// Self-checking testbench of the test access port.
`include "jtg_map.vh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin errors++; \
    $display("Error at %0t: got %h expected %h", $time, g, e); end end
module tb_jtg_tap;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [3:0] op; int len; logic [7:0] pin; logic [7:0] core;
                    logic [31:0] cap;} jtg_row_t;
    localparam logic [31:0] id_exp = {`JTG_ID_VERSION, `JTG_ID_PART, `JTG_ID_MANUF,
                                      `JTG_ID_LSB};
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic q;
    wire tck, tms, tdi, trstn, tdo, tdo_oe, tlr;
    logic [7:0] pin_in = 8'h00;
    logic [7:0] core_out = 8'h00;
    wire [7:0] core_in, pin_out;
    logic [7:0] upd_in, upd_out;
    logic [31:0] din, dout, exp_out;
    int errors = 0;
    int samples_checked = 0;
    jtg_row_t rows [7];

    // ==========
    // Clock, design and tester.
    always #5 clk = ~clk;
    jtg_tap u_dut (.clk_sys_i(clk), .resetn_i(resetn), .tck_i(tck), .tms_i(tms),
        .tdi_i(tdi), .trstn_i(trstn), .tdo_o(tdo), .tdo_oe_o(tdo_oe), .pin_in_i(pin_in),
        .core_in_o(core_in), .core_out_i(core_out), .pin_out_o(pin_out), .tlr_o(tlr));
    jtg_tester_model u_tst (.clk_sys_i(clk), .tdo_i(tdo), .tdo_oe_i(tdo_oe), .tck_o(tck),
        .tms_o(tms), .tdi_o(tdi), .trstn_o(trstn));

    // Prints the verdict and ends the run.
    task automatic summarize;
        if (errors == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ==========
    // Main sequence: table of instructions, then reset and odd cases.
    initial begin
        rows[0] = '{`JTG_OP_SAMPLE, 16, 8'h5a, 8'hc3, 32'h0};
        rows[1] = '{`JTG_OP_CLAMP, 1, 8'h0f, 8'h81, 32'h0};
        rows[2] = '{`JTG_OP_EXTEST, 16, 8'h33, 8'h7e, 32'h0};
        rows[3] = '{`JTG_OP_INTEST, 16, 8'h96, 8'h24, 32'h0};
        rows[4] = '{`JTG_OP_IDCODE, 32, 8'h00, 8'hff, id_exp};
        rows[5] = '{`JTG_OP_BYPASS, 1, 8'h11, 8'h22, 32'h0};
        rows[6] = '{4'h9, 1, 8'h44, 8'h88, 32'h0};
        repeat (3) @(negedge clk);
        resetn = 1'b1;
        repeat (2) @(negedge clk);
        `CHK(tlr, 1'b1)
        `CHK(tdo_oe, 1'b0)
        u_tst.scan(1'b0, 32'h0, 32, dout);
        `CHK(dout, id_exp)
        for (int i = 0; i < 7; i++) begin
            pin_in = rows[i].pin;
            core_out = rows[i].core;
            u_tst.scan(1'b1, {28'h0, rows[i].op}, 4, dout);
            `CHK(dout[3:0], `JTG_IR_CAPTURE)
            din = 32'h3c5a96e1 + 32'(i) * 32'h01010101;
            u_tst.scan(1'b0, din, 32, dout);
            exp_out = (rows[i].len == 16) ? {16'h0, rows[i].core, rows[i].pin} : rows[i].cap;
            `CHK(dout, exp_out | (din << rows[i].len))
            if (rows[i].len == 16) {upd_out, upd_in} = din[31:16];
            repeat (4) @(negedge clk);
            exp_out[7:0] = (rows[i].op inside {`JTG_OP_EXTEST, `JTG_OP_CLAMP}) ? upd_out
                                                                               : rows[i].core;
            `CHK(pin_out, exp_out[7:0])
            `CHK(core_in, (rows[i].op == `JTG_OP_INTEST) ? upd_in : rows[i].pin)
        end
        // Test reset in mid-shift must stop the shift and restore the code.
        for (int k = 0; k < 4; k++) u_tst.cyc(k == 0, 1'b1, q);
        `CHK(tdo_oe, 1'b1)
        u_tst.test_reset(6);
        `CHK(tlr, 1'b1)
        `CHK(tdo_oe, 1'b0)
        u_tst.scan(1'b0, 32'h0, 32, dout);
        `CHK(dout, id_exp)
        // The private register has no capture: a second scan returns the last byte of the first.
        u_tst.scan(1'b1, {28'h0, `JTG_OP_USER1}, 4, dout);
        u_tst.scan(1'b0, 32'ha1b2c3d4, 32, dout);
        u_tst.scan(1'b0, 32'h5e6f7081, 32, dout);
        `CHK(dout, {24'h6f7081, 8'ha1})
        // Mode select alone returns to the reset state and reloads the code.
        u_tst.to_reset();
        `CHK(tlr, 1'b1)
        u_tst.scan(1'b0, 32'h0, 32, dout);
        `CHK(dout, id_exp)
        // System reset in mid-run: outputs go to their reset levels at once.
        resetn = 1'b0;
        @(negedge clk);
        `CHK(tlr, 1'b1)
        `CHK(tdo_oe, 1'b0)
        `CHK(pin_out, 8'h00)
        `CHK(core_in, 8'h00)
        resetn = 1'b1;
        repeat (2) @(negedge clk);
        u_tst.scan(1'b0, 32'h0, 32, dout);
        `CHK(dout, id_exp)
        summarize();
    end
endmodule // tb_jtg_tap

// file: hw/jtg_map.vh
// Constants shared by the test access port: opcodes, lengths and code fields.
`ifndef JTG_MAP_VH
`define JTG_MAP_VH

// ==========================================================================
// Register lengths
// ==========================================================================
`define JTG_IR_W 4
`define JTG_ID_W 32
`define JTG_USR_W 8
`define JTG_PIN_W 8
`define JTG_BSR_W 16
`define JTG_SYNC_W 12

// ==========================================================================
// Instruction opcodes (all ones selects bypass)
// ==========================================================================
`define JTG_OP_EXTEST 4'h0
`define JTG_OP_SAMPLE 4'h1
`define JTG_OP_INTEST 4'h2
`define JTG_OP_IDCODE 4'h3
`define JTG_OP_CLAMP 4'h4
`define JTG_OP_USER1 4'h5
`define JTG_OP_BYPASS 4'hf
`define JTG_IR_CAPTURE 4'h1

// ==========================================================================
// Identification code fields (values are arbitrary, bit 0 is fixed at one)
// ==========================================================================
`define JTG_ID_VERSION 4'h1
`define JTG_ID_PART 16'h0a5c
`define JTG_ID_MANUF 11'h2b3
`define JTG_ID_LSB 1'b1

`endif

// file: hw/jtg_sync.v
// Two-stage synchroniser for a group of asynchronous pin inputs.
`include "jtg_map.vh"

module jtg_sync (
    input wire clk_sys_i,                     // System clock.
    input wire resetn_i,                      // Asynchronous reset, active low.
    input wire [`JTG_SYNC_W-1:0] async_i,     // Pin levels from outside.
    output reg [`JTG_SYNC_W-1:0] sync_o       // Levels safe to read.
);

    // ======================================================================
    // Synchroniser
    // ======================================================================
    reg [`JTG_SYNC_W-1:0] meta_reg;

    // The first stage feeds only the second; nothing else may look at it.
    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            meta_reg <= {`JTG_SYNC_W{1'b0}};
            sync_o <= {`JTG_SYNC_W{1'b0}};
        end else begin
            meta_reg <= async_i;
            sync_o <= meta_reg;
        end
    end

endmodule // jtg_sync

// file: hw/jtg_tap.v
// Test access port controller with bypass, identification and boundary scan.
`include "jtg_map.vh"

module jtg_tap (
    input wire clk_sys_i,                      // System clock, 100 MHz.
    input wire resetn_i,                       // Asynchronous reset, active low.
    input wire tck_i,                          // Test clock pin.
    input wire tms_i,                          // Test mode select pin.
    input wire tdi_i,                          // Serial data in pin.
    input wire trstn_i,                        // Test reset pin, active low.
    output reg tdo_o,                          // Serial data out pin.
    output reg tdo_oe_o,                       // High while data out is driven.
    input wire [`JTG_PIN_W-1:0] pin_in_i,      // Functional input pins.
    output reg [`JTG_PIN_W-1:0] core_in_o,     // Input values seen by the core.
    input wire [`JTG_PIN_W-1:0] core_out_i,    // Output values from the core.
    output reg [`JTG_PIN_W-1:0] pin_out_o,     // Values driven on output pins.
    output reg tlr_o                           // High in Test-Logic-Reset.
);

    // ======================================================================
    // Controller states, one-hot
    // ======================================================================
    localparam [15:0] S_TLR = 16'h0001;
    localparam [15:0] S_RTI = 16'h0002;
    localparam [15:0] S_SELDR = 16'h0004;
    localparam [15:0] S_CAPDR = 16'h0008;
    localparam [15:0] S_SHDR = 16'h0010;
    localparam [15:0] S_EX1DR = 16'h0020;
    localparam [15:0] S_PADR = 16'h0040;
    localparam [15:0] S_EX2DR = 16'h0080;
    localparam [15:0] S_UPDR = 16'h0100;
    localparam [15:0] S_SELIR = 16'h0200;
    localparam [15:0] S_CAPIR = 16'h0400;
    localparam [15:0] S_SHIR = 16'h0800;
    localparam [15:0] S_EX1IR = 16'h1000;
    localparam [15:0] S_PAIR = 16'h2000;
    localparam [15:0] S_EX2IR = 16'h4000;
    localparam [15:0] S_UPIR = 16'h8000;

    // ======================================================================
    // Functions
    // ======================================================================
    // Next controller state for a given mode select level.
    function [15:0] tap_next;
        input [15:0] st;
        input tms;
        begin
            case (st)
                S_TLR: tap_next = tms ? S_TLR : S_RTI;
                S_RTI: tap_next = tms ? S_SELDR : S_RTI;
                S_SELDR: tap_next = tms ? S_SELIR : S_CAPDR;
                S_CAPDR: tap_next = tms ? S_EX1DR : S_SHDR;
                S_SHDR: tap_next = tms ? S_EX1DR : S_SHDR;
                S_EX1DR: tap_next = tms ? S_UPDR : S_PADR;
                S_PADR: tap_next = tms ? S_EX2DR : S_PADR;
                S_EX2DR: tap_next = tms ? S_UPDR : S_SHDR;
                S_UPDR: tap_next = tms ? S_SELDR : S_RTI;
                S_SELIR: tap_next = tms ? S_TLR : S_CAPIR;
                S_CAPIR: tap_next = tms ? S_EX1IR : S_SHIR;
                S_SHIR: tap_next = tms ? S_EX1IR : S_SHIR;
                S_EX1IR: tap_next = tms ? S_UPIR : S_PAIR;
                S_PAIR: tap_next = tms ? S_EX2IR : S_PAIR;
                S_EX2IR: tap_next = tms ? S_UPIR : S_SHIR;
                S_UPIR: tap_next = tms ? S_SELDR : S_RTI;
                default: tap_next = S_TLR;
            endcase
        end
    endfunction

    // ======================================================================
    // Pin synchronisation and test clock edges
    // ======================================================================
    wire [`JTG_SYNC_W-1:0] sync_w;
    wire tck_s;
    wire tms_s;
    wire tdi_s;
    wire trstn_s;
    wire [`JTG_PIN_W-1:0] pin_in_s;
    reg tck_d_reg;

    jtg_sync u_sync (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .async_i({pin_in_i, trstn_i, tdi_i, tms_i, tck_i}),
        .sync_o(sync_w)
    );

    assign tck_s = sync_w[0];
    assign tms_s = sync_w[1];
    assign tdi_s = sync_w[2];
    assign trstn_s = sync_w[3];
    assign pin_in_s = sync_w[`JTG_SYNC_W-1:4];

    // Previous test clock level, for edge detection on the synchronised copy.
    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tck_d_reg <= 1'b0;
        end else begin
            tck_d_reg <= tck_s;
        end
    end

    wire tck_rise = tck_s & ~tck_d_reg;
    wire tck_fall = ~tck_s & tck_d_reg;

    // ======================================================================
    // Controller state machine
    // ======================================================================
    reg [15:0] state_reg;

    // Test reset acts without waiting for any test clock edge; the test
    // clock may stand still while the pin is low.
    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_reg <= S_TLR;
        end else if (!trstn_s) begin
            state_reg <= S_TLR;
        end else if (tck_rise) begin
            state_reg <= tap_next(state_reg, tms_s);
        end
    end

    // ======================================================================
    // Instruction register
    // ======================================================================
    reg [`JTG_IR_W-1:0] ir_sh_reg;
    reg [`JTG_IR_W-1:0] ir_reg;

    // Shift stage on rising edges; the active opcode changes on the falling
    // edge in Update-IR so that decoding never glitches mid-shift.
    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ir_sh_reg <= `JTG_IR_CAPTURE;
            ir_reg <= `JTG_OP_IDCODE;
        end else if (state_reg == S_TLR) begin
            ir_reg <= `JTG_OP_IDCODE;
        end else begin
            if (tck_rise && state_reg == S_CAPIR) begin
                ir_sh_reg <= `JTG_IR_CAPTURE;
            end else if (tck_rise && state_reg == S_SHIR) begin
                ir_sh_reg <= {tdi_s, ir_sh_reg[`JTG_IR_W-1:1]};
            end
            if (tck_fall && state_reg == S_UPIR) begin
                ir_reg <= ir_sh_reg;
            end
        end
    end

    // ======================================================================
    // Instruction decode
    // ======================================================================
    wire op_extest = (ir_reg == `JTG_OP_EXTEST);
    wire op_sample = (ir_reg == `JTG_OP_SAMPLE);
    wire op_intest = (ir_reg == `JTG_OP_INTEST);
    wire op_idcode = (ir_reg == `JTG_OP_IDCODE);
    wire op_clamp = (ir_reg == `JTG_OP_CLAMP);
    wire op_user = (ir_reg == `JTG_OP_USER1);
    wire sel_bsr = op_extest | op_sample | op_intest;
    // Unknown opcodes fall back to bypass, as does clamp.
    wire sel_byp = ~(sel_bsr | op_idcode | op_user);

    // ======================================================================
    // Data registers
    // ======================================================================
    reg byp_reg;
    reg [`JTG_ID_W-1:0] id_reg;
    reg [`JTG_USR_W-1:0] usr_reg;
    reg [`JTG_BSR_W-1:0] bsr_reg;
    reg [`JTG_BSR_W-1:0] bsr_upd_reg;

    wire [`JTG_ID_W-1:0] id_code = {`JTG_ID_VERSION, `JTG_ID_PART, `JTG_ID_MANUF,
                                    `JTG_ID_LSB};
    wire cap_dr = tck_rise && state_reg == S_CAPDR;
    wire sh_dr = tck_rise && state_reg == S_SHDR;

    // Only the selected register captures or shifts; the others hold.
    // Boundary cells: low half inputs, high half outputs.
    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            byp_reg <= 1'b0;
            id_reg <= {`JTG_ID_W{1'b0}};
            usr_reg <= {`JTG_USR_W{1'b0}};
            bsr_reg <= {`JTG_BSR_W{1'b0}};
        end else begin
            if (sel_byp && cap_dr) begin
                byp_reg <= 1'b0;
            end else if (sel_byp && sh_dr) begin
                byp_reg <= tdi_s;
            end
            if (op_idcode && cap_dr) begin
                id_reg <= id_code;
            end else if (op_idcode && sh_dr) begin
                id_reg <= {tdi_s, id_reg[`JTG_ID_W-1:1]};
            end
            if (op_user && sh_dr) begin
                usr_reg <= {tdi_s, usr_reg[`JTG_USR_W-1:1]};
            end
            if (sel_bsr && cap_dr) begin
                bsr_reg <= {core_out_i, pin_in_s};
            end else if (sel_bsr && sh_dr) begin
                bsr_reg <= {tdi_s, bsr_reg[`JTG_BSR_W-1:1]};
            end
        end
    end

    // Update latches; sample loads them too, as a preload for later tests.
    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            bsr_upd_reg <= {`JTG_BSR_W{1'b0}};
        end else if (tck_fall && state_reg == S_UPDR && sel_bsr) begin
            bsr_upd_reg <= bsr_reg;
        end
    end

    // ======================================================================
    // Serial output on falling test clock edges
    // ======================================================================
    reg dr_bit;

    always @* begin
        dr_bit = byp_reg;
        if (op_idcode) begin
            dr_bit = id_reg[0];
        end else if (op_user) begin
            dr_bit = usr_reg[0];
        end else if (sel_bsr) begin
            dr_bit = bsr_reg[0];
        end
    end

    // Driver is enabled only while shifting, as the standard expects.
    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tdo_o <= 1'b0;
            tdo_oe_o <= 1'b0;
        end else if (!trstn_s) begin
            tdo_o <= 1'b0;
            tdo_oe_o <= 1'b0;
        end else if (state_reg == S_TLR) begin
            // Data out holds here: entry by mode select follows a rising test
            // clock, and the line may only move while that clock is low.
            tdo_oe_o <= 1'b0;
        end else if (tck_fall) begin
            tdo_o <= (state_reg == S_SHIR) ? ir_sh_reg[0] : dr_bit;
            tdo_oe_o <= (state_reg == S_SHIR) || (state_reg == S_SHDR);
        end
    end

    // ======================================================================
    // Pin and core multiplexers
    // ======================================================================
    // Functional outputs pass through one register, so pins lag the core by a
    // system clock (inputs also cross the two sync stages); this keeps every output on a flip-flop.
    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pin_out_o <= {`JTG_PIN_W{1'b0}};
            core_in_o <= {`JTG_PIN_W{1'b0}};
            tlr_o <= 1'b1;
        end else begin
            pin_out_o <= (op_extest || op_clamp) ?
                         bsr_upd_reg[`JTG_BSR_W-1:`JTG_PIN_W] : core_out_i;
            core_in_o <= op_intest ? bsr_upd_reg[`JTG_PIN_W-1:0] : pin_in_s;
            tlr_o <= (state_reg == S_TLR);
        end
    end

endmodule // jtg_tap
